//--- logic/smc_lock_det.sv
// lock detector: four boundaries to lock, four misses to drop it
`timescale 1ns/10ps
`default_nettype none
module smc_lock_det
  import smc_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // one tick per reference cycle, boundary seen in that cycle
  input wire logic clear,
  input wire logic tick,
  input wire logic found,
  // lock state
  output logic locked
);
  smc_lock_state_t state_ff, nxt_state;
  logic [2:0] run_ff, nxt_run;

  wire run_done = run_ff == LOCK_RUN - 3'd1;
  // a good cycle while hunting, or a miss while locked, extends the run
  wire counts = (state_ff == LK_HUNT) ? found : !found;

  always_comb begin
    nxt_state = state_ff;
    nxt_run = run_ff;
    if (tick) begin
      nxt_run = counts ? run_ff + 3'd1 : 3'd0;
      if (counts && run_done) begin
        nxt_run = 3'd0;
        unique case (state_ff)
          LK_HUNT: nxt_state = LK_LOCKED;
          LK_LOCKED: nxt_state = LK_HUNT;
        endcase
      end
    end
    if (clear) begin
      nxt_state = LK_HUNT;
      nxt_run = 3'd0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= LK_HUNT;
      run_ff <= 3'd0;
    end else begin
      state_ff <= nxt_state;
      run_ff <= nxt_run;
    end
  end

  assign locked = state_ff == LK_LOCKED;

  lock_gain_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !locked && tick && found && run_ff == 3'd3 && !clear |=> locked)
    else $error("lock not declared after four boundaries");
  lock_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    locked && !clear && !(tick && !found && run_ff == 3'd3) |=> locked)
    else $error("lock dropped before four missed boundaries");
endmodule
`default_nettype wire

//--- logic/smc_top.sv
// top level: serdes mode control with axi4-lite register access
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - deserializer sleeps only when its power-down and output enable are low.
// - serializer sleeps whenever its power-down is low.
// - in power down every output floats; the loop stops only in sleep.
// - after power-down rises, serializer initializes for 1026 transmit clocks.
// - leaving power down, lock indicator stays high until lock.
// - driver enable low floats the serial pair; high enables it.
// - driver enable high resumes the previous serializer state.
// - receive enable low floats data and clock; lock stays driven.
// - unlocked: lock indicator high, data and clock float.
// - recovered clock runs only while locked; edge follows select.
// - undriven serial input forces the line and lock indicator high.
// - sync requests are ORed; six cycles high sends 1026 patterns.
// - request still held after the burst keeps sync going.
// - parallel input latched on falling edge, or rising when selected.
// - parallel output strobed on falling edge, or rising when selected.
// - lock indicator goes low once the loop has locked.
// - each word is framed by start bit one and stop bit zero.
// - each 12-bit symbol is shifted out on the serial line.
// - lock after four equal boundaries, lost after four misses.
// - data is sent only when enabled, powered and no sync requested.
module smc_top
  import smc_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address, data and response
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read address and data
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // serializer pins
  input wire logic transmit_clock,
  input wire logic [DATA_W-1:0] parallel_in,
  output logic serial_out_p,
  output logic serial_out_n,
  output logic serial_out_oe,
  // deserializer pins
  input wire logic serial_in_p,
  input wire logic serial_in_n,
  input wire logic local_reference_clock,
  output logic [DATA_W-1:0] parallel_out,
  output logic parallel_out_oe,
  output logic recovered_clock,
  output logic recovered_clock_oe,
  output logic lock_n,
  output logic lock_n_oe
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  localparam int PIN_W = DATA_W + 4;
  logic [PIN_W-1:0] pin_meta_ff, pin_sync_ff;
  wire [PIN_W-1:0] pins = {local_reference_clock, serial_in_n,
                           serial_in_p, parallel_in, transmit_clock};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta_ff <= '0;
      pin_sync_ff <= '0;
    end else begin
      pin_meta_ff <= pins;
      pin_sync_ff <= pin_meta_ff;
    end
  end

  wire transmit_clock_s = pin_sync_ff[0];
  wire [DATA_W-1:0] par_s = pin_sync_ff[DATA_W:1];
  wire sin_p_s = pin_sync_ff[DATA_W+1];
  wire sin_n_s = pin_sync_ff[DATA_W+2];
  wire ref_s = pin_sync_ff[DATA_W+3];

  // ---------------------------------------------------------------
  // control register fields
  // ---------------------------------------------------------------
  logic [7:0] ctrl_ff;
  wire tx_pdn = ctrl_ff[CT_TX_PDN];
  wire drv_en = ctrl_ff[CT_DRV_EN];
  wire sync_a = ctrl_ff[CT_SYNC_A];
  wire sync_b = ctrl_ff[CT_SYNC_B];
  wire tx_edge = ctrl_ff[CT_TX_EDGE];
  wire rx_pdn = ctrl_ff[CT_RX_PDN];
  wire rx_oe = ctrl_ff[CT_RX_OE];
  wire rx_edge = ctrl_ff[CT_RX_EDGE];

  // ---------------------------------------------------------------
  // serializer
  // ---------------------------------------------------------------
  logic transmit_clock_d_ff;
  logic [11:0] tx_sh_ff;
  logic tx_p_ff, tx_n_ff, tx_oe_ff;
  logic init_busy, sync_active;
  wire transmit_clock_rise = transmit_clock_s & ~transmit_clock_d_ff;
  wire transmit_clock_fall = ~transmit_clock_s & transmit_clock_d_ff;
  wire tx_strobe = tx_edge ? transmit_clock_rise : transmit_clock_fall;
  wire sync_any = sync_a | sync_b;
  wire send_data = drv_en & tx_pdn & ~sync_any & ~sync_active
                   & ~init_busy;
  wire [11:0] data_sym = {STOP_BIT, par_s, START_BIT};
  wire [11:0] nxt_sym = send_data ? data_sym : SYNC_SYMBOL;
  smc_tx_seq u_tx_seq (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(transmit_clock_rise),
    .power_down_n(tx_pdn),
    .sync_req(sync_any),
    .init_busy(init_busy),
    .sync_active(sync_active)
  );
  // line idles at the stop level; a transmit_clock above aclk/12 cuts symbols short
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      transmit_clock_d_ff <= 1'b0;
      tx_sh_ff <= 12'h000;
      tx_p_ff <= 1'b0;
      tx_n_ff <= 1'b1;
      tx_oe_ff <= 1'b0;
    end else begin
      transmit_clock_d_ff <= transmit_clock_s;
      if (tx_strobe && tx_pdn) tx_sh_ff <= nxt_sym;
      else tx_sh_ff <= {1'b0, tx_sh_ff[11:1]};
      tx_p_ff <= tx_sh_ff[0];
      tx_n_ff <= ~tx_sh_ff[0];
      // sequencer runs on while the pair floats, so it resumes in place
      tx_oe_ff <= drv_en & tx_pdn & ~init_busy;
    end
  end

  assign serial_out_p = tx_p_ff;
  assign serial_out_n = tx_n_ff;
  assign serial_out_oe = tx_oe_ff;

  // ---------------------------------------------------------------
  // deserializer framing
  // ---------------------------------------------------------------
  logic bit_d_ff, ref_d_ff, found_ff;
  logic [3:0] rx_cnt_ff;
  logic [10:0] rx_bits_ff;
  logic [DATA_W-1:0] rx_word_ff;
  logic locked;
  wire rx_sleep = ~rx_pdn & ~rx_oe;
  // an undriven pair reads equal on both legs
  wire failsafe = sin_p_s == sin_n_s;
  wire rx_bit = failsafe | sin_p_s;
  wire start_seen = rx_bit & ~bit_d_ff & (rx_cnt_ff == 4'h0);
  wire frame_end = rx_cnt_ff == FRAME_LAST;
  wire frame_ok = frame_end & (rx_bit == STOP_BIT);
  wire ref_tick = ref_s & ~ref_d_ff;
  wire ref_fall = ~ref_s & ref_d_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bit_d_ff <= 1'b1;
      ref_d_ff <= 1'b0;
      rx_cnt_ff <= 4'h0;
      rx_bits_ff <= 11'h000;
      rx_word_ff <= '0;
      found_ff <= 1'b0;
    end else begin
      bit_d_ff <= rx_bit;
      ref_d_ff <= ref_s;
      if (rx_sleep) rx_cnt_ff <= 4'h0;
      else if (start_seen) rx_cnt_ff <= 4'h1;
      else if (frame_end) rx_cnt_ff <= 4'h0;
      else if (rx_cnt_ff != 4'h0) rx_cnt_ff <= rx_cnt_ff + 4'h1;
      if (rx_cnt_ff != 4'h0) rx_bits_ff <= {rx_bit, rx_bits_ff[10:1]};
      if (frame_ok) rx_word_ff <= rx_bits_ff[10:1];
      // a boundary in the same cycle as the tick is kept
      found_ff <= frame_ok | (found_ff & ~ref_tick);
    end
  end

  smc_lock_det u_lock_det (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear(rx_sleep | failsafe),
    .tick(ref_tick),
    .found(found_ff | frame_ok),
    .locked(locked)
  );
  // ---------------------------------------------------------------
  // deserializer outputs
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] par_out_ff;
  logic par_oe_ff, rclk_ff, rclk_oe_ff, lock_n_ff, lock_oe_ff;
  // new data appears on the edge opposite the strobe edge
  wire par_update = rx_edge ? ref_fall : ref_tick;
  wire rx_live = locked & ~failsafe & rx_pdn;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      par_out_ff <= '0;
      par_oe_ff <= 1'b0;
      rclk_ff <= 1'b0;
      rclk_oe_ff <= 1'b0;
      lock_n_ff <= 1'b1;
      lock_oe_ff <= 1'b0;
    end else begin
      if (par_update) par_out_ff <= rx_word_ff;
      par_oe_ff <= rx_live & rx_oe;
      rclk_ff <= rx_live & ref_s;
      rclk_oe_ff <= rx_live & rx_oe;
      lock_n_ff <= ~rx_live;
      lock_oe_ff <= rx_pdn;
    end
  end

  assign parallel_out = par_out_ff;
  assign parallel_out_oe = par_oe_ff;
  assign recovered_clock = rclk_ff;
  assign recovered_clock_oe = rclk_oe_ff;
  assign lock_n = lock_n_ff;
  assign lock_n_oe = lock_oe_ff;

  // ---------------------------------------------------------------
  // axi4-lite write channel
  // ---------------------------------------------------------------
  logic awready_ff, wready_ff, bvalid_ff;
  logic [1:0] bresp_ff;
  logic [7:0] aw_addr_ff, w_data_ff;
  logic w_strb_ff;

  wire aw_take = awvalid & awready_ff;
  wire w_take = wvalid & wready_ff;
  wire wr_go = ~awready_ff & ~wready_ff & ~bvalid_ff;
  wire b_done = bvalid_ff & bready;
  wire wr_hit = aw_addr_ff == ADDR_CTRL;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      aw_addr_ff <= 8'h00;
      w_data_ff <= 8'h00;
      w_strb_ff <= 1'b0;
      ctrl_ff <= CTRL_RESET;
    end else begin
      if (aw_take) begin
        awready_ff <= 1'b0;
        aw_addr_ff <= awaddr;
      end
      if (w_take) begin
        wready_ff <= 1'b0;
        w_data_ff <= wdata[7:0];
        w_strb_ff <= wstrb[0];
      end
      if (wr_go) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        if (wr_hit && w_strb_ff) ctrl_ff <= w_data_ff;
      end
      if (b_done) begin
        bvalid_ff <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff <= 1'b1;
      end
    end
  end

  assign awready = awready_ff;
  assign wready = wready_ff;
  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;

  // ---------------------------------------------------------------
  // axi4-lite read channel
  // ---------------------------------------------------------------
  logic arready_ff, rvalid_ff;
  logic [1:0] rresp_ff;
  logic [31:0] rdata_ff;
  logic [31:0] status_word;
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[ST_LOCKED] = locked;
    status_word[ST_INIT] = init_busy;
    status_word[ST_SYNC] = sync_active;
    status_word[ST_FAILSAFE] = failsafe;
    status_word[ST_RX_SLEEP] = rx_sleep;
    status_word[ST_TX_ON] = send_data;
  end

  wire ar_take = arvalid & arready_ff;
  wire rd_ctrl = araddr == ADDR_CTRL;
  wire rd_stat = araddr == ADDR_STATUS;
  wire rd_word = araddr == ADDR_RXWORD;
  wire rd_hit = rd_ctrl | rd_stat | rd_word;
  wire [31:0] rd_mux = rd_ctrl ? {24'h00_0000, ctrl_ff} :
                       rd_stat ? status_word :
                       rd_word ? {22'h0, rx_word_ff} : 32'h0000_0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rresp_ff <= RESP_OKAY;
      rdata_ff <= 32'h0000_0000;
    end else if (ar_take) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_mux;
      rresp_ff <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_ff && rready) begin
      rvalid_ff <= 1'b0;
      arready_ff <= 1'b1;
    end
  end

  assign arready = arready_ff;
  assign rvalid = rvalid_ff;
  assign rdata = rdata_ff;
  assign rresp = rresp_ff;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  rx_sleep_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rx_sleep |=> !lock_n_oe && !parallel_out_oe && !locked)
    else $error("deserializer sleep left outputs driven");
  tx_sleep_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !tx_pdn |=> !serial_out_oe ##1 !serial_out_oe)
    else $error("serializer drives while powered down");
  rx_pd_hiz_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !rx_pdn |=> !lock_n_oe && !recovered_clock_oe)
    else $error("deserializer outputs driven in power down");
  drv_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !drv_en |=> !serial_out_oe)
    else $error("serial pair driven with driver disabled");
  rx_hiz_mode_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rx_pdn && !rx_oe |=> lock_n_oe && !parallel_out_oe && !recovered_clock_oe)
    else $error("receive high impedance mode wrong");
  unlock_hiz_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !locked |=> lock_n && !parallel_out_oe && !recovered_clock)
    else $error("unlocked deserializer drives data or clock");
  fail_safe_a: assert property (@(posedge aclk) disable iff (!aresetn)
    failsafe |=> lock_n ##1 !locked)
    else $error("undriven input did not force lock high");
  lock_low_a: assert property (@(posedge aclk) disable iff (!aresetn)
    locked && !failsafe && rx_pdn |=> !lock_n)
    else $error("lock indicator not low while locked");
  frame_load_a: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_strobe && tx_pdn && send_data
    |=> tx_sh_ff == {STOP_BIT, $past(par_s), START_BIT})
    else $error("data symbol framed wrongly");
  sync_pat_a: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_strobe && tx_pdn && sync_any |=> tx_sh_ff == SYNC_SYMBOL)
    else $error("data sent while sync requested");
endmodule
`default_nettype wire

//--- logic/smc_tx_seq.sv
// serializer sequencer: initialization and sync pattern bursts
`timescale 1ns/10ps
`default_nettype none
module smc_tx_seq
  import smc_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // one pulse per transmit clock cycle, and controls
  input wire logic tick,
  input wire logic power_down_n,
  input wire logic sync_req,
  // sequencer state
  output logic init_busy,
  output logic sync_active
);
  smc_tx_state_t state_ff, nxt_state;
  logic [10:0] cnt_ff, nxt_cnt;
  logic [2:0] req_cnt_ff;

  wire qual = sync_req & (req_cnt_ff == SYNC_QUAL);
  wire init_last = cnt_ff == INIT_CYCLES - 11'd1;
  wire sync_last = cnt_ff == SYNC_PATTERNS - 11'd1;

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    unique case (state_ff)
      TX_SLEEP: begin
        nxt_state = TX_INIT;
        nxt_cnt = 11'd0;
      end
      TX_INIT: if (tick) begin
        nxt_cnt = cnt_ff + 11'd1;
        if (init_last) begin
          nxt_state = TX_RUN;
        end
      end
      TX_RUN: if (qual) begin
        nxt_state = TX_SYNC;
        nxt_cnt = 11'd0;
      end
      TX_SYNC: if (tick) begin
        nxt_cnt = cnt_ff + 11'd1;
        if (sync_last) begin
          // a request still held restarts a full burst
          nxt_state = qual ? TX_SYNC : TX_RUN;
          nxt_cnt = 11'd0;
        end
      end
    endcase
    if (!power_down_n) begin
      nxt_state = TX_SLEEP;
      nxt_cnt = 11'd0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= TX_SLEEP;
      cnt_ff <= 11'd0;
      req_cnt_ff <= 3'd0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      if (!sync_req) req_cnt_ff <= 3'd0;
      else if (tick && req_cnt_ff != SYNC_QUAL)
        req_cnt_ff <= req_cnt_ff + 3'd1;
    end
  end

  // a just-woken serializer counts as initializing, so the pair stays off
  assign init_busy = state_ff == TX_INIT
                     || (state_ff == TX_SLEEP && power_down_n);
  assign sync_active = state_ff == TX_SYNC;

  init_done_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_ff == TX_INIT && tick && cnt_ff == 11'd1025 && power_down_n
    |=> state_ff == TX_RUN && !init_busy)
    else $error("init did not end after 1026 cycles");
  sync_start_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_ff == TX_RUN && sync_req && req_cnt_ff == 3'd6 && power_down_n
    |=> sync_active)
    else $error("qualified sync request did not start a burst");
endmodule
`default_nettype wire

//--- pkg/smc_pkg.sv
// package: constants and types for the serdes mode control block
package smc_pkg;

  // ---------------------------------------------------------------
  // register map, byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_RXWORD = 8'h08;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // control and status field positions
  // ---------------------------------------------------------------
  localparam int CT_TX_PDN = 0;
  localparam int CT_DRV_EN = 1;
  localparam int CT_SYNC_A = 2;
  localparam int CT_SYNC_B = 3;
  localparam int CT_TX_EDGE = 4;
  localparam int CT_RX_PDN = 5;
  localparam int CT_RX_OE = 6;
  localparam int CT_RX_EDGE = 7;
  localparam int ST_LOCKED = 0;
  localparam int ST_INIT = 1;
  localparam int ST_SYNC = 2;
  localparam int ST_FAILSAFE = 3;
  localparam int ST_RX_SLEEP = 4;
  localparam int ST_TX_ON = 5;

  // ---------------------------------------------------------------
  // link framing and timing counts
  // ---------------------------------------------------------------
  localparam int DATA_W = 10;
  localparam logic START_BIT = 1'b1;
  localparam logic STOP_BIT = 1'b0;
  localparam logic [11:0] SYNC_SYMBOL = 12'h03F;
  localparam logic [3:0] FRAME_LAST = 4'hB;
  localparam logic [10:0] INIT_CYCLES = 11'd1026;
  localparam logic [10:0] SYNC_PATTERNS = 11'd1026;
  localparam logic [2:0] SYNC_QUAL = 3'd6;
  localparam logic [2:0] LOCK_RUN = 3'd4;

  typedef enum logic [1:0] {
    TX_SLEEP = 2'b00,
    TX_INIT = 2'b01,
    TX_RUN = 2'b10,
    TX_SYNC = 2'b11
  } smc_tx_state_t;

  typedef enum logic {
    LK_HUNT = 1'b0,
    LK_LOCKED = 1'b1
  } smc_lock_state_t;

endpackage

//--- testbench/serdes_mode_control_tb_top.sv
// testbench top: mode, lock and sync checks through the register bus
`timescale 1ns/10ps
`default_nettype none
`define CHK(n,e,s) begin cmp_count++; if ((s) !== (e)) begin n_fail++; \
  $display("[ERR] %s exp %h got %h", n, e, s); end end
module serdes_mode_control_tb_top
  import smc_pkg::*;
;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic transmit_clock, local_reference_clock, serial_in_p, serial_in_n;
  logic serial_out_p, serial_out_n, serial_out_oe;
  logic recovered_clock, recovered_clock_oe, parallel_out_oe, lock_n, lock_n_oe;
  logic [DATA_W-1:0] parallel_in, parallel_out, tx_word;
  int n_fail, cmp_count;
  // ctrl, transmit_clock ticks to wait, status mask, status value
  logic [39:0] rows [11] = '{40'h00_0002_33_10, 40'h63_000A_33_02,
    40'h63_0406_33_21, 40'h23_0004_33_21, 40'h43_0004_30_20,
    40'h61_000A_2B_08, 40'h63_000A_23_21, 40'hF3_000A_23_21,
    40'h62_0004_22_00, 40'h63_000A_22_02, 40'h63_0406_23_21};

  smc_top dut_u (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .transmit_clock,
    .parallel_in, .serial_out_p, .serial_out_n, .serial_out_oe,
    .serial_in_p, .serial_in_n, .local_reference_clock, .parallel_out,
    .parallel_out_oe, .recovered_clock, .recovered_clock_oe, .lock_n,
    .lock_n_oe);
  smc_far_end far_u (.serial_out_p, .serial_out_n, .serial_out_oe,
    .tx_word, .transmit_clock, .local_reference_clock, .parallel_in,
    .serial_in_p, .serial_in_n);

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // aw and w offered together; each dropped once its ready is seen
  task automatic axw(input logic [7:0] a, input logic [7:0] v);
    logic ad;
    logic wd;
    ad = 1'b0;
    wd = 1'b0;
    awaddr <= a;
    wdata <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      ad |= awready;
      wd |= wready;
    end while (!(ad && wd));
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
  endtask

  task automatic axr(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
  endtask

  task automatic tk(input int n);
    repeat (n) @(posedge transmit_clock);
    @(posedge aclk);
  endtask

  task automatic st(input logic [7:0] m, input logic [7:0] v);
    axr(ADDR_STATUS);
    `CHK("status", v, d[7:0] & m)
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // the longest legal run is about 550 us of bus and link time
  initial begin
    #900000;
    n_fail++;
    wrap_up();
  end

  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, arvalid, awaddr, araddr, wdata} = '0;
    bready = 1'b1;
    rready = 1'b1;
    wstrb = 4'hF;
    tx_word = 10'h2A5;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    `CHK("drv_oe", 1'b0, serial_out_oe)
    `CHK("lock_oe", 1'b0, lock_n_oe)
    axr(ADDR_CTRL);
    `CHK("ctrl", 32'h0, d)
    for (int i = 0; i < 11; i++) begin
      axw(ADDR_CTRL, rows[i][39:32]);
      tk(rows[i][31:16]);
      st(rows[i][15:8], rows[i][7:0]);
    end
    // after the loop: status, received word, output enables and pair polarity
    st(8'h21, 8'h21);
    axr(ADDR_RXWORD);
    `CHK("rxword", 32'h2A5, d)
    `CHK("pout", tx_word, parallel_out)
    `CHK("oes", 4'b1110, {parallel_out_oe, recovered_clock_oe, lock_n_oe, lock_n})
    `CHK("pair", ~serial_out_p, serial_out_n)
    axw(ADDR_CTRL, 8'h23);
    tk(1);
    `CHK("rx_hiz", 4'b0010, {parallel_out_oe, recovered_clock_oe, lock_n_oe, lock_n})
    axw(ADDR_CTRL, 8'h03);
    tk(1);
    `CHK("rx_pdn", 3'b000, {parallel_out_oe, recovered_clock_oe, lock_n_oe})
    axw(ADDR_CTRL, 8'h67);
    tk(3);
    axw(ADDR_CTRL, 8'h63);
    tk(2);
    st(8'h04, 8'h00);
    axw(ADDR_CTRL, 8'h6B);
    tk(8);
    axw(ADDR_CTRL, 8'h63);
    tk(990);
    st(8'h04, 8'h04);
    tk(50);
    st(8'h04, 8'h00);
    axw(ADDR_CTRL, 8'h67);
    tk(1040);
    st(8'h04, 8'h04);
    axw(ADDR_CTRL, 8'h63);
    axr(8'h0C);
    `CHK("unmapped", {RESP_SLVERR, 32'h0}, {r, d})
    axw(ADDR_STATUS, 8'hFF);
    `CHK("ro_resp", RESP_SLVERR, r)
    axr(ADDR_CTRL);
    `CHK("ctrl", 32'h63, d)
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    `CHK("rst_oe", 3'h0, {serial_out_oe, parallel_out_oe, lock_n_oe})
    axr(ADDR_CTRL);
    `CHK("rst_ctrl", 32'h0, d)
    wrap_up();
  end
endmodule
`default_nettype wire

//--- testbench/smc_far_end.sv
// far-end model: source clocks, parallel word and the serial pair
`timescale 1ns/10ps
`default_nettype none
module smc_far_end (
  // pair from the block
  input wire logic serial_out_p,
  input wire logic serial_out_n,
  input wire logic serial_out_oe,
  input wire logic [9:0] tx_word,
  // source side
  output logic transmit_clock,
  output logic local_reference_clock,
  output logic [9:0] parallel_in,
  output logic serial_in_p,
  output logic serial_in_n
);
  logic flt = 1'b0;
  // bench rate, kept slow so one 12-bit symbol fits in a word cycle
  initial begin
    transmit_clock = 1'b0;
    forever #62.5 transmit_clock = ~transmit_clock;
  end
  // reference at the same rate, phase unrelated to the source clock
  initial begin
    local_reference_clock = 1'b0;
    #37;
    forever #62.5 local_reference_clock = ~local_reference_clock;
  end
  // released pair: both legs equal and wandering, never a clean level
  always @(posedge transmit_clock) flt <= ~flt;
  assign serial_in_p = serial_out_oe ? serial_out_p : flt;
  assign serial_in_n = serial_out_oe ? serial_out_n : flt;
  assign parallel_in = tx_word;
endmodule
`default_nettype wire
